// *** inc/rank_decode_pkg.sv ***
/*
 * constants shared by the rank decoder and its ecc core: widths,
 * register offsets, field positions, reset values and modes.
 * assumes a single 50 mhz clock and an 8-bit register port.
 */
`default_nettype none
package rank_decode_pkg;
    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int ADDR_W = 33;  // host byte address, up to 8 gb
    localparam int DATA_W = 64;  // protected word
    localparam int CHK_W = 8;  // check bits, 72-bit lane
    localparam int SYN_W = 7;  // hamming part of the check bits
    localparam int CW_TOP = 71;  // highest hamming position
    localparam int RANKS = 4;  // ranks per channel
    localparam int BND_W = 8;  // boundary in 64 mb units
    localparam int BND_LSB = 26;  // host bit of one boundary unit
    localparam int REG_AW = 6;
    localparam int REG_DW = 8;
    localparam int GEOM_W = 3;
    localparam int PAGE_W = 3;
    localparam int ROW_W = 14;
    localparam int COL_W = 10;
    localparam int BANK_W = 3;
    // ****************************************************************
    // address layout
    // ****************************************************************
    localparam int COL_LSB = 3;  // lowest column bit on the host bus
    localparam int CHAN_BIT = 6;  // channel select when interleaved
    localparam int HI_LSB = 7;  // first host bit above the select
    localparam int ODD_LSB = 4;  // odd rank page field in its byte
    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [5:0] OFF_BND = 6'h00;  // 8 boundaries a0..b3
    localparam logic [5:0] OFF_PAGE = 6'h08;  // 4 bytes, 2 ranks each
    localparam logic [5:0] OFF_TIM = 6'h0C;  // timing a, b
    localparam logic [5:0] OFF_CTL = 6'h0E;  // dram control a, b
    localparam logic [5:0] OFF_GEOM = 6'h10;  // 8 geometry codes
    localparam logic [5:0] OFF_MODE = 6'h18;
    localparam logic [5:0] OFF_STAT = 6'h19;
    localparam logic [5:0] OFF_ERRCNT = 6'h1A;
    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int MODE_ECC_BIT = 2;  // mode register ecc enable
    localparam int GEOM_X16_BIT = 2;  // geometry code: x16 parts
    localparam logic [1:0] DEN_256 = 2'h0;
    localparam logic [1:0] DEN_512 = 2'h1;
    localparam logic [1:0] DEN_1G = 2'h2;
    localparam int ST_SBE = 0;  // sticky status bits
    localparam int ST_DBE = 1;
    localparam int ST_MISS = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    // ****************************************************************
    // channel organisation, one-hot
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_SINGLE = 3'h1,
        MODE_ASYM = 3'h2,
        MODE_INTER = 3'h4
    } chan_mode_t;
    localparam logic [1:0] SEL_INTER = 2'h2;  // mode register code
    localparam logic [1:0] SEL_ASYM = 2'h1;
endpackage : rank_decode_pkg
`default_nettype wire

// *** hw/secded_core.sv ***
/*
 * single-error-correct, double-error-detect code over one 64-bit
 * word, purely combinational. assumes the caller registers results.
 */
`default_nettype none
module secded_core (
    // write side
    input wire logic [rank_decode_pkg::DATA_W-1:0] gen_data,
    output logic [rank_decode_pkg::CHK_W-1:0] gen_chk,
    // read side
    input wire logic [rank_decode_pkg::DATA_W-1:0] rx_data,
    input wire logic [rank_decode_pkg::CHK_W-1:0] rx_chk,
    output logic [rank_decode_pkg::DATA_W-1:0] fix_data,
    output logic single_err,
    output logic double_err
);
    import rank_decode_pkg::*;

    // ****************************************************************
    // hamming syndrome: data sits on positions that are not 2**k
    // ****************************************************************
    function automatic logic [SYN_W-1:0] syn_of(
        input logic [DATA_W-1:0] d);
        logic [SYN_W-1:0] s;
        int k;
        s = '0;
        k = 0;
        for (int p = 1; p <= CW_TOP; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (d[k]) begin
                    s = s ^ SYN_W'(p);
                end
                k++;
            end
        end
        return s;
    endfunction : syn_of

    logic [SYN_W-1:0] syn;  // read syndrome
    logic par;  // overall parity of the received lane

    // check bits: hamming part plus overall parity
    always_comb begin
        gen_chk[SYN_W-1:0] = syn_of(gen_data);
        gen_chk[CHK_W-1] = ^gen_data ^ ^syn_of(gen_data);
    end

    // classify and repair; a syndrome on a check position leaves data
    always_comb begin
        int k;
        k = 0;
        syn = syn_of(rx_data) ^ rx_chk[SYN_W-1:0];
        par = ^rx_data ^ ^rx_chk;
        fix_data = rx_data;
        single_err = par;
        double_err = !par && (syn != '0);
        for (int p = 1; p <= CW_TOP; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (par && syn == SYN_W'(p)) begin
                    fix_data[k] = !rx_data[k];
                end
                k++;
            end
        end
    end
endmodule : secded_core
`default_nettype wire

// *** hw/rank_decoder.sv ***
/*
 * rank organisation, host address split and ecc for a two-channel
 * ddr2 controller. assumes requests come from logic on mclk and an
 * 8-bit register port with read data one cycle after the strobe.
 */
`default_nettype none
module rank_decoder (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [rank_decode_pkg::REG_AW-1:0] reg_addr,
    input wire logic [rank_decode_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rank_decode_pkg::REG_DW-1:0] reg_rdata,
    // host request
    input wire logic req_valid,
    input wire logic [rank_decode_pkg::ADDR_W-1:0] req_addr,
    // decoded target
    output logic dec_valid,
    output logic dec_hit,
    output logic dec_chan,
    output logic [1:0] dec_rank,
    output logic [rank_decode_pkg::BANK_W-1:0] dec_bank,
    output logic [rank_decode_pkg::ROW_W-1:0] dec_row,
    output logic [rank_decode_pkg::COL_W-1:0] dec_col,
    output logic [rank_decode_pkg::PAGE_W-1:0] dec_page,
    output logic [rank_decode_pkg::REG_DW-1:0] dec_timing,
    // per-channel dram controls
    output logic [rank_decode_pkg::REG_DW-1:0] ctl_chan_a,
    output logic [rank_decode_pkg::REG_DW-1:0] ctl_chan_b,
    // write data to the lane
    input wire logic wr_valid,
    input wire logic [rank_decode_pkg::DATA_W-1:0] wr_data,
    output logic wr_out_valid,
    output logic [rank_decode_pkg::DATA_W-1:0] wr_out_data,
    output logic [rank_decode_pkg::CHK_W-1:0] wr_out_chk,
    // read data from the lane
    input wire logic rd_valid,
    input wire logic [rank_decode_pkg::DATA_W-1:0] rd_data,
    input wire logic [rank_decode_pkg::CHK_W-1:0] rd_chk,
    output logic rd_out_valid,
    output logic [rank_decode_pkg::DATA_W-1:0] rd_out_data,
    output logic rd_sbe,
    output logic rd_dbe
);
    import rank_decode_pkg::*;

    // ****************************************************************
    // field split of a rank-local offset by part geometry
    // ****************************************************************
    function automatic logic [ROW_W+BANK_W+COL_W-1:0] split(
        input logic [ADDR_W-1:0] off, input logic [GEOM_W-1:0] g);
        logic [ADDR_W-1:0] s;
        logic [COL_W-1:0] c;
        logic [BANK_W-1:0] b;
        logic [ROW_W-1:0] r;
        int nc;
        int nb;
        int nr;
        // widths per density and organisation
        nc = (g[1:0] == DEN_256 && g[GEOM_X16_BIT]) ? 9 : 10;
        nb = (g[1:0] == DEN_1G) ? 3 : 2;
        nr = (!g[GEOM_X16_BIT] && g[1:0] != DEN_256) ? 14 : 13;
        // column first, then bank, then row
        s = off >> COL_LSB;
        c = s[COL_W-1:0] & COL_W'((1 << nc) - 1);
        s = s >> nc;
        b = s[BANK_W-1:0] & BANK_W'((1 << nb) - 1);
        if (nb == 3) begin
            // 8-bank parts: b2 lands just above the column
            b = {b[0], b[1], b[2]};
        end
        s = s >> nb;
        r = s[ROW_W-1:0] & ROW_W'((1 << nr) - 1);
        return {r, b, c};
    endfunction : split

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    logic [BND_W-1:0] bnd_q [2*RANKS];  // a0..a3, b0..b3
    logic [REG_DW-1:0] page_q [RANKS];  // two page fields each
    logic [REG_DW-1:0] tim_q [2];  // channel timing
    logic [REG_DW-1:0] ctl_q [2];  // refresh mode, rate, controls
    logic [GEOM_W-1:0] geom_q [2*RANKS];  // density and width
    logic [REG_DW-1:0] mode_q;  // organisation and ecc enable
    logic [REG_DW-1:0] stat_q;  // sticky events
    logic [REG_DW-1:0] errcnt_q;  // corrected word count
    chan_mode_t mode;
    logic ecc_en;

    // mode code to one-hot organisation
    always_comb begin
        if (mode_q[1:0] == SEL_INTER) begin
            mode = MODE_INTER;
        end else if (mode_q[1:0] == SEL_ASYM) begin
            mode = MODE_ASYM;
        end else begin
            mode = MODE_SINGLE;
        end
        ecc_en = mode_q[MODE_ECC_BIT];
    end

    // software writes, decoded by range
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 2 * RANKS; i++) begin
                bnd_q[i] <= RST_BYTE;
                geom_q[i] <= '0;
            end
            for (int i = 0; i < RANKS; i++) begin
                page_q[i] <= RST_BYTE;
            end
            tim_q[0] <= RST_BYTE;
            tim_q[1] <= RST_BYTE;
            ctl_q[0] <= RST_BYTE;
            ctl_q[1] <= RST_BYTE;
            mode_q <= RST_BYTE;
        end else if (reg_wr) begin
            if (reg_addr < OFF_PAGE) begin
                bnd_q[reg_addr[2:0]] <= reg_wdata;
            end else if (reg_addr < OFF_TIM) begin
                // reserved bits 3 and 7 stay zero
                page_q[reg_addr[1:0]] <= reg_wdata & 8'h77;
            end else if (reg_addr < OFF_CTL) begin
                tim_q[reg_addr[0]] <= reg_wdata;
            end else if (reg_addr < OFF_GEOM) begin
                ctl_q[reg_addr[0]] <= reg_wdata;
            end else if (reg_addr < OFF_MODE) begin
                geom_q[reg_addr[2:0]] <= reg_wdata[GEOM_W-1:0];
            end else if (reg_addr == OFF_MODE) begin
                mode_q <= reg_wdata & 8'h07;
            end
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= RST_BYTE;
        end else if (!reg_rd) begin
            reg_rdata <= RST_BYTE;
        end else if (reg_addr < OFF_PAGE) begin
            reg_rdata <= bnd_q[reg_addr[2:0]];
        end else if (reg_addr < OFF_TIM) begin
            reg_rdata <= page_q[reg_addr[1:0]];
        end else if (reg_addr < OFF_CTL) begin
            reg_rdata <= tim_q[reg_addr[0]];
        end else if (reg_addr < OFF_GEOM) begin
            reg_rdata <= ctl_q[reg_addr[0]];
        end else if (reg_addr < OFF_MODE) begin
            reg_rdata <= REG_DW'(geom_q[reg_addr[2:0]]);
        end else if (reg_addr == OFF_MODE) begin
            reg_rdata <= mode_q;
        end else if (reg_addr == OFF_STAT) begin
            reg_rdata <= stat_q;
        end else if (reg_addr == OFF_ERRCNT) begin
            reg_rdata <= errcnt_q;
        end else begin
            reg_rdata <= RST_BYTE;
        end
    end

    // ****************************************************************
    // rank lookup and address split
    // ****************************************************************
    logic hit;  // some rank holds the address
    logic chan;  // target channel
    logic [1:0] rank;
    logic [2:0] slot;  // channel * 4 + rank
    logic [BND_W-1:0] base;  // boundary below the hit rank
    logic [ADDR_W:0] diff;  // address minus base
    logic [ADDR_W-1:0] off;  // rank-local offset

    always_comb begin
        logic [BND_W-1:0] hi;
        hi = BND_W'(req_addr[ADDR_W-1:BND_LSB]);
        hit = 1'b0;
        chan = 1'b0;
        rank = 2'h0;
        base = RST_BYTE;
        if (mode == MODE_INTER) begin
            // one register stands for the rank pair
            for (int i = RANKS - 1; i >= 0; i--) begin
                if (hi < bnd_q[i]) begin
                    hit = 1'b1;
                    rank = 2'(i);
                    base = (i == 0) ? RST_BYTE : bnd_q[(i+RANKS-1)%RANKS];
                end
            end
            chan = req_addr[CHAN_BIT];
        end else begin
            // a fills first, b continues above a's top
            for (int i = 2 * RANKS - 1; i >= 0; i--) begin
                if (hi < bnd_q[i]) begin
                    hit = 1'b1;
                    chan = (i >= RANKS);
                    rank = 2'(i % RANKS);
                    base = (i == 0) ? RST_BYTE : bnd_q[(i+7)%8];
                end
            end
        end
        slot = {chan, rank};
        diff = {1'b0, req_addr} - {base, BND_LSB'(0)};
        if (mode == MODE_INTER) begin
            // drop the select bit, upper bits move down
            off = {1'b0, diff[ADDR_W-1:HI_LSB], diff[CHAN_BIT-1:0]};
        end else begin
            off = diff[ADDR_W-1:0];
        end
    end

    // decoded target one cycle on; ranks share mclk
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dec_valid <= 1'b0;
            dec_hit <= 1'b0;
            dec_chan <= 1'b0;
            dec_rank <= 2'h0;
            {dec_row, dec_bank, dec_col} <= '0;
            dec_page <= '0;
            dec_timing <= RST_BYTE;
        end else begin
            dec_valid <= req_valid;
            dec_hit <= req_valid && hit;
            dec_chan <= chan;
            dec_rank <= rank;
            {dec_row, dec_bank, dec_col} <= split(off, geom_q[slot]);
            // page fields packed two to a byte
            dec_page <= rank[0] ?
                page_q[slot[2:1]][ODD_LSB+:PAGE_W] :
                page_q[slot[2:1]][PAGE_W-1:0];
            dec_timing <= tim_q[chan];
        end
    end

    // per-channel control straight from its register
    assign ctl_chan_a = ctl_q[0];
    assign ctl_chan_b = ctl_q[1];

    // ****************************************************************
    // ecc on the 72-bit lane
    // ****************************************************************
    logic [CHK_W-1:0] gen_chk;
    logic [DATA_W-1:0] fix_data;
    logic sbe;
    logic dbe;

    secded_core secded_core_inst (
        .gen_data(wr_data),
        .gen_chk(gen_chk),
        .rx_data(rd_data),
        .rx_chk(rd_chk),
        .fix_data(fix_data),
        .single_err(sbe),
        .double_err(dbe)
    );

    // write lane: check bits only while enabled
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_out_valid <= 1'b0;
            wr_out_data <= '0;
            wr_out_chk <= '0;
        end else begin
            wr_out_valid <= wr_valid;
            wr_out_data <= wr_data;
            wr_out_chk <= ecc_en ? gen_chk : '0;
        end
    end

    // read lane: correct when enabled, else pass
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_out_valid <= 1'b0;
            rd_out_data <= '0;
            rd_sbe <= 1'b0;
            rd_dbe <= 1'b0;
        end else begin
            rd_out_valid <= rd_valid;
            rd_out_data <= ecc_en ? fix_data : rd_data;
            rd_sbe <= rd_valid && ecc_en && sbe;
            rd_dbe <= rd_valid && ecc_en && dbe;
        end
    end

    // write-one-to-clear mask for the status byte
    logic [REG_DW-1:0] stat_clr;
    assign stat_clr = (reg_wr && reg_addr == OFF_STAT) ? reg_wdata : '0;

    // sticky status, write one to clear; a new event wins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= RST_BYTE;
        end else begin
            stat_q <= stat_q & ~stat_clr;
            stat_q[ST_SBE] <= rd_sbe ||
                (stat_q[ST_SBE] && !stat_clr[ST_SBE]);
            stat_q[ST_DBE] <= rd_dbe ||
                (stat_q[ST_DBE] && !stat_clr[ST_DBE]);
            stat_q[ST_MISS] <= (dec_valid && !dec_hit) ||
                (stat_q[ST_MISS] && !stat_clr[ST_MISS]);
        end
    end

    // corrected word count, saturating; a write to it clears it unless a count lands that cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            errcnt_q <= RST_BYTE;
        end else if (rd_sbe && errcnt_q != CNT_MAX) begin
            errcnt_q <= errcnt_q + 8'h01;
        end else if (reg_wr && reg_addr == OFF_ERRCNT) begin
            errcnt_q <= RST_BYTE;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence wr_tim_a;
        reg_wr && reg_addr == OFF_TIM;
    endsequence
    sequence rd_tim_a;
        reg_rd && reg_addr == OFF_TIM;
    endsequence

    AST_TIM_READBACK: assert property (
        @(posedge mclk) disable iff (!rst_b)
        wr_tim_a ##1 rd_tim_a |=> reg_rdata == $past(reg_wdata, 2))
        else $error("timing register readback mismatch");

    AST_NO_HIT_ABOVE_TOP: assert property (
        @(posedge mclk) disable iff (!rst_b)
        req_valid && mode != MODE_INTER &&
        BND_W'(req_addr[ADDR_W-1:BND_LSB]) >= bnd_q[2*RANKS-1] &&
        bnd_q[RANKS-1] <= bnd_q[2*RANKS-1]
        |=> dec_valid && !dec_hit)
        else $error("address above top decoded to a rank");

    AST_INTER_CHAN: assert property (
        @(posedge mclk) disable iff (!rst_b)
        req_valid && mode == MODE_INTER
        |=> dec_chan == $past(req_addr[CHAN_BIT]))
        else $error("interleaved channel not host bit 6");

    AST_LOW_COLUMN: assert property (
        @(posedge mclk) disable iff (!rst_b)
        req_valid && hit && base == RST_BYTE
        |=> dec_col[2:0] == $past(req_addr[5:3]))
        else $error("low column bits misplaced");

    AST_DEC_LATENCY: assert property (
        @(posedge mclk) disable iff (!rst_b)
        req_valid ##1 !req_valid |-> dec_valid ##1 !dec_valid)
        else $error("decode not one cycle after request");

    AST_ECC_OFF_PASS: assert property (
        @(posedge mclk) disable iff (!rst_b)
        rd_valid && !ecc_en |=> rd_out_data == $past(rd_data)
        && !rd_sbe && !rd_dbe && rd_out_valid)
        else $error("data altered while ecc is off");

    AST_ECC_CLEAN: assert property (
        @(posedge mclk) disable iff (!rst_b)
        rd_valid && ecc_en && rd_chk == gen_chk && rd_data == wr_data
        |=> !rd_sbe && !rd_dbe && rd_out_data == $past(rd_data))
        else $error("clean word flagged or changed");

    AST_ERR_EXCL: assert property (
        @(posedge mclk) disable iff (!rst_b)
        !(rd_sbe && rd_dbe))
        else $error("single and double error together");

    AST_CHK_ZERO_OFF: assert property (
        @(posedge mclk) disable iff (!rst_b)
        wr_valid && !ecc_en |=> wr_out_chk == '0 && wr_out_valid)
        else $error("check bits driven while ecc is off");

    AST_SBE_STICKY: assert property (
        @(posedge mclk) disable iff (!rst_b)
        rd_sbe |=> stat_q[ST_SBE])
        else $error("corrected error not latched");
endmodule : rank_decoder
`default_nettype wire

// *** tb/dimm_lane_model.sv ***
/* one ecc lane of the dimms: stores words, returns them.
 * assumes the bench pulses rd_go and sets the flip mask. */
`default_nettype none
module dimm_lane_model (
    // bench side
    input wire logic mclk,
    input wire logic rd_go,
    input wire logic [71:0] flip,
    // controller side
    input wire logic wr_out_valid,
    input wire logic [63:0] wr_out_data,
    input wire logic [7:0] wr_out_chk,
    output logic rd_valid,
    output logic [63:0] rd_data,
    output logic [7:0] rd_chk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [71:0] word_q; // word with check bits
    // store, return with flipped cells, toggle when idle
    always_ff @(posedge mclk) begin
        if (wr_out_valid)
            word_q <= {wr_out_chk, wr_out_data};
        rd_valid <= rd_go;
        {rd_chk, rd_data} <= rd_go ? word_q ^ flip : ~{rd_chk, rd_data};
    end
endmodule : dimm_lane_model
`default_nettype wire

// *** tb/tb_rank_decoder.sv ***
/* self-checking bench for the rank decoder.
 * assumes the lane model answers reads one cycle after rd_go. */
`default_nettype none
module tb_rank_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import rank_decode_pkg::*;
    logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
    logic req_valid = 0, wr_valid = 0, rd_go = 0, rd_valid;
    logic [5:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata, rv;
    logic [32:0] req_addr = '0;
    logic dec_valid, dec_hit, dec_chan, wr_out_valid;
    logic rd_out_valid, rd_sbe, rd_dbe;
    logic [1:0] dec_rank;
    logic [2:0] dec_bank, dec_page;
    logic [13:0] dec_row;
    logic [9:0] dec_col;
    logic [7:0] dec_timing, ctl_chan_a, ctl_chan_b, wr_out_chk, rd_chk;
    logic [63:0] wr_data = '0, wr_out_data, rd_data, rd_out_data;
    logic [71:0] flip = '0;
    int mismatches = 0, num_checks = 0;
    localparam logic [63:0] W = 64'hA5A5_0F0F_1234_5678; // test word
    rank_decoder rank_decoder_inst (.mclk, .rst_b, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req_addr, .dec_valid,
        .dec_hit, .dec_chan, .dec_rank, .dec_bank, .dec_row, .dec_col,
        .dec_page, .dec_timing, .ctl_chan_a, .ctl_chan_b, .wr_valid,
        .wr_data, .wr_out_valid, .wr_out_data, .wr_out_chk, .rd_valid,
        .rd_data, .rd_chk, .rd_out_valid, .rd_out_data, .rd_sbe, .rd_dbe);
    dimm_lane_model dimm_lane_model_inst (.mclk, .rd_go, .flip,
        .wr_out_valid, .wr_out_data, .wr_out_chk, .rd_valid, .rd_data,
        .rd_chk);
    // 50 mhz clock
    always #10 mclk = ~mclk;
    task check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : check
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask : wr
    task rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask : rd
    task dec(input logic [32:0] a);
        @(posedge mclk);
        req_valid <= 1'h1;
        req_addr <= a;
        @(posedge mclk);
        req_valid <= 1'h0;
        #1 check(64'(dec_valid), 64'h1);
    endtask : dec
    task put_word(input logic [7:0] exp_chk_zero);
        @(posedge mclk);
        wr_valid <= 1'h1;
        wr_data <= W;
        @(posedge mclk);
        wr_valid <= 1'h0;
        #1 check(wr_out_data, W);
        check(64'(wr_out_valid), 64'h1);
        if (exp_chk_zero != 0)
            check(64'(wr_out_chk), 64'h0); // no check bits
    endtask : put_word
    task lane(input logic [71:0] f, input logic [63:0] d, input logic [1:0] e);
        @(posedge mclk);
        rd_go <= 1'h1;
        flip <= f;
        @(posedge mclk);
        rd_go <= 1'h0;
        @(posedge mclk);
        #1 check(64'(rd_out_valid), 64'h1);
        check(rd_out_data, d);
        check(64'({rd_sbe, rd_dbe}), 64'(e));
    endtask : lane
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // hang guard
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        give_verdict;
    end
    // main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'h1;
        // a0, a1 and b0 populated, 64 mb each
        for (int i = 0; i < 8; i++)
            wr(6'(i), i == 0 ? 8'h1 : (i < 4 ? 8'h2 : 8'h3));
        rd(6'h01, rv);
        check(64'(rv), 64'h2); // boundary readback
        wr(OFF_PAGE, 8'hFF);
        rd(OFF_PAGE, rv);
        check(64'(rv), 64'h77); // two 3-bit fields
        wr(6'h0A, 8'h35);
        rd(6'h20, rv);
        check(64'(rv), 64'h0); // unmapped place reads zero
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= OFF_TIM;
        reg_wdata <= 8'h11;
        @(posedge mclk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h1;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1 check(64'(reg_rdata), 64'h11); // back-to-back
        wr(6'h0D, 8'h22);
        wr(OFF_CTL, 8'h5A);
        wr(6'h0F, 8'hA5);
        #1 check(64'({ctl_chan_a, ctl_chan_b}), 64'h5AA5);
        wr(6'h14, 8'h06); // b0 holds 1 gb x16 parts
        wr(OFF_MODE, {6'h0, SEL_ASYM});
        dec(33'h400_2018);
        check(64'({dec_hit, dec_chan, dec_rank}), 64'h9);
        check(64'({dec_bank, dec_col}), 64'h403);
        check(64'(dec_page), 64'h7); // odd rank field
        check(64'(dec_timing), 64'h11); // channel timing
        dec(33'h801_2008);
        check(64'({dec_hit, dec_chan, dec_rank}), 64'hC);
        check(64'({dec_page, dec_timing}), 64'h522);
        check(64'({dec_bank, dec_col}), 64'h1001); // 8 banks
        check(64'(dec_row), 64'h1); // row above bank
        dec(33'hC00_0000);
        check(64'(dec_hit), 64'h0); // past the top
        rd(OFF_STAT, rv);
        check(64'(rv), 64'h4); // miss flagged
        wr(OFF_MODE, {6'h0, SEL_INTER}); // equal capacity
        dec(33'h48);
        check(64'({dec_hit, dec_chan, dec_rank, dec_col}),
            64'h3001);
        dec(33'h80);
        check(64'({dec_hit, dec_chan, dec_rank, dec_col}),
            64'h2008);
        put_word(8'h1);
        lane(72'h1, W ^ 64'h1, 2'h0); // raw pass when off
        wr(OFF_MODE, 8'h04);
        put_word(8'h0);
        lane(72'h0, W, 2'h0); // clean word
        lane(72'h10, W, 2'h2); // single corrected
        lane(72'h30, W ^ 64'h30, 2'h1); // double detected
        rd(OFF_ERRCNT, rv);
        check(64'(rv), 64'h1); // one corrected word
        rd(OFF_STAT, rv);
        check(64'(rv), 64'h7); // sticky events
        wr(OFF_STAT, 8'h07);
        rd(OFF_STAT, rv);
        check(64'(rv), 64'h0); // write one clears
        give_verdict;
    end
endmodule : tb_rank_decoder
`default_nettype wire
